/* File: shared/pio_pkg.sv */
package pio_pkg;

    // register byte offsets on the apb bus, one aligned word each
    localparam logic [7:0] OFS_PORT_A = 8'h00;
    localparam logic [7:0] OFS_PORT_A_DIR = 8'h04;
    localparam logic [7:0] OFS_PORT_B = 8'h08;
    localparam logic [7:0] OFS_PORT_B_DIR = 8'h0c;
    localparam logic [7:0] OFS_PORT_C = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h14;

    // port geometry and reset values
    localparam int PORT_W = 8;
    localparam int APB_DW = 32;
    localparam int APB_AW = 8;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] OUT_RESET = 8'h00;
    localparam logic [7:0] ALL_INPUT = 8'hff;
    localparam logic [23:0] RDATA_PAD = 24'h000000;
    localparam logic [29:0] MODE_PAD = 30'h00000000;

    // operating mode strap codes
    localparam logic [1:0] MODE_INTERNAL = 2'h0;
    localparam logic [1:0] MODE_EXTERNAL = 2'h1;
    localparam logic [1:0] MODE_DEVELOP = 2'h2;

    // cycles after reset release before the strap is taken (two sync stages)
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    localparam logic [1:0] STRAP_STEP = 2'h1;

    // off-chip cycle states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_T1 = 5'h02,
        ST_T2 = 5'h04,
        ST_T3 = 5'h08,
        ST_T4 = 5'h10
    } pio_cyc_e;

endpackage : pio_pkg

/* File: verilog/pio_ports.sv */
`timescale 1ns/1ps

// Contract
// - In internal rom mode three separate 8-bit ports port_a, port_b and port_c are offered.
// - Every pin of port_a and port_b has its own direction bit, 1 for output and 0 for input.
// - port_c only drives outputs and owns no direction register.
// - Reset clears both direction registers so all port_a and port_b pins start as inputs.
// - Reading port_a or port_b returns the driven output value for every pin set as output.
// - Writing port_a, port_b or port_c updates the value driven on that port's output pins.
// - In external rom mode port_c is rebuilt by an outside latch on the upper data byte, written by io_write_strobe.
// - In external rom mode an outside buffer gated by io_read_strobe supplies port_b, which is then input only.
// - In development mode port_a is taken too, so no parallel port is offered at all.
// - Latch and buffer accesses run the off-chip memory cycle with io_read_strobe and io_write_strobe timing.
// - An outside read holds the address T1 to T4, asserts the strobe T2 to T4 and samples data at the end of T3; the code samples it at the end of T2.
// - An outside write drives data from T2 until the next T1 and asserts the strobe T2 to T4.
module pio_ports #(
    parameter int PW = pio_pkg::PORT_W,
    parameter int AW = pio_pkg::APB_AW
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] mode_strap,
    input wire logic [PW-1:0] port_a_in,
    output logic [PW-1:0] port_a_out,
    output logic [PW-1:0] port_a_oe_n,
    input wire logic [PW-1:0] port_b_in,
    output logic [PW-1:0] port_b_out,
    output logic [PW-1:0] port_b_oe_n,
    output logic [PW-1:0] port_c_out,
    output logic [AW-1:0] ext_addr,
    input wire logic [PW-1:0] ext_data_in,
    output logic [PW-1:0] ext_data_out,
    output logic [PW-1:0] ext_data_oe_n,
    output logic io_read_strobe_n,
    output logic io_write_strobe_n
);

    // whole module state in one record
    typedef struct packed {
        logic [PW-1:0] sa1;
        logic [PW-1:0] sa2;
        logic [PW-1:0] sb1;
        logic [PW-1:0] sb2;
        logic [PW-1:0] sd1;
        logic [PW-1:0] sd2;
        logic [1:0] sm1;
        logic [1:0] sm2;
        logic [1:0] strap_cnt;
        logic mode_ok;
        logic [1:0] mode;
        logic [PW-1:0] out_a;
        logic [PW-1:0] out_b;
        logic [PW-1:0] out_c;
        logic [PW-1:0] dir_a;
        logic [PW-1:0] dir_b;
        pio_pkg::pio_cyc_e st;
        logic ext_wr;
        logic [AW-1:0] ext_addr;
        logic [PW-1:0] ext_dout;
        logic ext_drive;
        logic rd_n;
        logic wr_n;
        logic [31:0] prdata;
        logic pslverr;
    } pio_state_s;

    pio_state_s q;
    pio_state_s d;

    // true when the offset names one of our registers
    function automatic logic is_mapped(input logic [AW-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        is_mapped = (o == pio_pkg::OFS_PORT_A) || (o == pio_pkg::OFS_PORT_A_DIR) ||
                    (o == pio_pkg::OFS_PORT_B) || (o == pio_pkg::OFS_PORT_B_DIR) ||
                    (o == pio_pkg::OFS_PORT_C) || (o == pio_pkg::OFS_MODE);
    endfunction : is_mapped

    // output pins return the latch, input pins the synchronised level
    function automatic logic [PW-1:0] pin_view(input logic [PW-1:0] dir, input logic [PW-1:0] dout,
                                               input logic [PW-1:0] sync);
        pin_view = (dir & dout) | (~dir & sync);
    endfunction : pin_view

    // mode decode; before the strap is taken all ports stay quiet
    logic mode_int;
    logic mode_ext;
    logic a_en;
    logic b_en;
    logic c_en;
    assign mode_int = q.mode_ok && (q.mode == pio_pkg::MODE_INTERNAL);
    assign mode_ext = q.mode_ok && (q.mode == pio_pkg::MODE_EXTERNAL);
    assign a_en = mode_int || mode_ext;
    assign b_en = mode_int;
    assign c_en = mode_int;

    // bus phases
    logic setup;
    logic access;
    logic idle;
    logic ext_req;
    logic [7:0] ofs;
    assign ofs = 8'(paddr);
    assign setup = ce && psel && !penable;
    assign access = ce && psel && penable;
    assign idle = (q.st == pio_pkg::ST_IDLE);
    // port_b read and port_c write leave the chip in external rom mode
    assign ext_req = mode_ext && (((ofs == pio_pkg::OFS_PORT_B) && !pwrite) ||
                                  ((ofs == pio_pkg::OFS_PORT_C) && pwrite));

    // slave answers once no off-chip cycle is running; never while ce is low
    assign pready = access && idle;

    // next state
    always_comb begin
        logic [PW-1:0] rv;
        rv = pio_pkg::OUT_RESET;
        d = q;
        // two-stage synchronisers; first stages feed only the second
        d.sa1 = port_a_in;
        d.sa2 = q.sa1;
        d.sb1 = port_b_in;
        d.sb2 = q.sb1;
        d.sd1 = ext_data_in;
        d.sd2 = q.sd1;
        d.sm1 = mode_strap;
        d.sm2 = q.sm1;
        // the strap is taken once, after it has crossed both stages
        if (!q.mode_ok) begin
            if (q.strap_cnt == pio_pkg::STRAP_WAIT) begin
                d.mode_ok = 1'b1;
                d.mode = q.sm2;
            end else begin
                d.strap_cnt = q.strap_cnt + pio_pkg::STRAP_STEP;
            end
        end

        // setup phase: decide the answer or launch an off-chip cycle
        if (setup && idle) begin
            d.pslverr = !is_mapped(paddr);
            d.prdata = {pio_pkg::RDATA_PAD, pio_pkg::OUT_RESET};
            if (ext_req) begin
                d.st = pio_pkg::ST_T1;
                d.ext_wr = pwrite;
                d.ext_addr = paddr;
                d.ext_dout = pwdata[PW-1:0];
            end else if (!pwrite) begin
                unique case (ofs)
                    pio_pkg::OFS_PORT_A: rv = a_en ? pin_view(q.dir_a, q.out_a, q.sa2) : pio_pkg::OUT_RESET;
                    pio_pkg::OFS_PORT_B: rv = b_en ? pin_view(q.dir_b, q.out_b, q.sb2) : pio_pkg::OUT_RESET;
                    pio_pkg::OFS_PORT_C: rv = (c_en || mode_ext) ? q.out_c : pio_pkg::OUT_RESET;
                    pio_pkg::OFS_PORT_A_DIR: rv = q.dir_a;
                    pio_pkg::OFS_PORT_B_DIR: rv = q.dir_b;
                    default: rv = pio_pkg::OUT_RESET;
                endcase
                if (ofs == pio_pkg::OFS_MODE) begin
                    d.prdata = {pio_pkg::MODE_PAD, q.mode};
                end else begin
                    d.prdata = {pio_pkg::RDATA_PAD, rv};
                end
            end
        end

        // off-chip cycle, four clocks long
        if (ce) begin
            unique case (q.st)
                pio_pkg::ST_IDLE: d.st = d.st;
                pio_pkg::ST_T1: begin
                    d.st = pio_pkg::ST_T2;
                    d.ext_drive = q.ext_wr; // write data from T2 onward
                end
                pio_pkg::ST_T2: d.st = pio_pkg::ST_T3;
                pio_pkg::ST_T3: d.st = pio_pkg::ST_T4;
                pio_pkg::ST_T4: begin
                    d.st = pio_pkg::ST_IDLE;
                    if (q.ext_wr) begin
                        d.out_c = q.ext_dout; // shadow for read back
                    end else begin
                        // strobed level has crossed both stages by now; the buffer must settle within T2
                        d.prdata = {pio_pkg::RDATA_PAD, q.sd2};
                    end
                end
                default: d.st = pio_pkg::ST_IDLE;
            endcase
        end
        // write data is released only when the next cycle begins
        if (d.st == pio_pkg::ST_T1) begin
            d.ext_drive = 1'b0;
        end
        // strobes low through T2..T4 of their own kind
        d.rd_n = !((d.st == pio_pkg::ST_T2 || d.st == pio_pkg::ST_T3 || d.st == pio_pkg::ST_T4) &&
                   !d.ext_wr);
        d.wr_n = !((d.st == pio_pkg::ST_T2 || d.st == pio_pkg::ST_T3 || d.st == pio_pkg::ST_T4) &&
                   d.ext_wr);

        // internal writes take effect at the completing edge only
        if (pready && pwrite && !ext_req) begin
            unique case (ofs)
                pio_pkg::OFS_PORT_A: if (a_en) d.out_a = pwdata[PW-1:0];
                pio_pkg::OFS_PORT_B: if (b_en) d.out_b = pwdata[PW-1:0];
                pio_pkg::OFS_PORT_C: if (c_en) d.out_c = pwdata[PW-1:0];
                pio_pkg::OFS_PORT_A_DIR: d.dir_a = pwdata[PW-1:0];
                pio_pkg::OFS_PORT_B_DIR: d.dir_b = pwdata[PW-1:0];
                default: d.dir_a = d.dir_a;
            endcase
        end
    end

    // one register stage for all state; ce low holds everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.sa1 <= pio_pkg::OUT_RESET;
            q.sa2 <= pio_pkg::OUT_RESET;
            q.sb1 <= pio_pkg::OUT_RESET;
            q.sb2 <= pio_pkg::OUT_RESET;
            q.sd1 <= pio_pkg::OUT_RESET;
            q.sd2 <= pio_pkg::OUT_RESET;
            q.sm1 <= pio_pkg::MODE_INTERNAL;
            q.sm2 <= pio_pkg::MODE_INTERNAL;
            q.strap_cnt <= 2'h0;
            q.mode_ok <= 1'b0;
            q.mode <= pio_pkg::MODE_INTERNAL;
            q.out_a <= pio_pkg::OUT_RESET;
            q.out_b <= pio_pkg::OUT_RESET;
            q.out_c <= pio_pkg::OUT_RESET;
            q.dir_a <= pio_pkg::DIR_RESET;
            q.dir_b <= pio_pkg::DIR_RESET;
            q.st <= pio_pkg::ST_IDLE;
            q.ext_wr <= 1'b0;
            q.ext_addr <= '0;
            q.ext_dout <= pio_pkg::OUT_RESET;
            q.ext_drive <= 1'b0;
            q.rd_n <= 1'b1;
            q.wr_n <= 1'b1;
            q.prdata <= 32'h00000000;
            q.pslverr <= 1'b0;
        end else if (ce) begin
            q <= d;
        end
    end

    // pin drive; three separate ports so each has its own enables
    assign port_a_out = q.out_a;
    assign port_b_out = q.out_b;
    assign port_c_out = c_en ? q.out_c : pio_pkg::OUT_RESET;
    assign port_a_oe_n = a_en ? ~q.dir_a : pio_pkg::ALL_INPUT;
    assign port_b_oe_n = b_en ? ~q.dir_b : pio_pkg::ALL_INPUT;

    // off-chip upper byte and strobes, all from flops
    assign ext_addr = q.ext_addr;
    assign ext_data_out = q.ext_dout;
    assign ext_data_oe_n = q.ext_drive ? ~pio_pkg::ALL_INPUT : pio_pkg::ALL_INPUT;
    assign io_read_strobe_n = q.rd_n;
    assign io_write_strobe_n = q.wr_n;

    // bus answer
    assign prdata = q.prdata;
    assign pslverr = q.pslverr && pready;

    // a direction write is seen on the enables one clock later
    a_dir_to_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && pwrite && ofs == pio_pkg::OFS_PORT_A_DIR && a_en) |=>
        (port_a_oe_n == ~$past(pwdata[PW-1:0])))
        else $error("port_a enables do not follow direction write");

    // a port_c write reaches the pins on the next clock
    a_portc_write: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && pwrite && ofs == pio_pkg::OFS_PORT_C && c_en) |=>
        (port_c_out == $past(pwdata[PW-1:0])))
        else $error("port_c pins did not take the written value");

    // read of port_a shows the driven value on output pins
    a_read_outputs: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && idle && !pwrite && ofs == pio_pkg::OFS_PORT_A && a_en) |=>
        ((prdata[PW-1:0] & q.dir_a) == (q.out_a & q.dir_a)))
        else $error("port_a read lost output pin value");

    // read strobe low exactly three clocks
    a_rd_strobe_len: assert property (@(posedge pclk) disable iff (!presetn || !ce)
        $fell(io_read_strobe_n) |-> !io_read_strobe_n[*3] ##1 io_read_strobe_n)
        else $error("read strobe width is not three clocks");

    // write strobe low exactly three clocks with data driven
    a_wr_strobe_len: assert property (@(posedge pclk) disable iff (!presetn || !ce)
        $fell(io_write_strobe_n) |-> (!io_write_strobe_n && ext_data_oe_n == ~pio_pkg::ALL_INPUT)[*3]
        ##1 io_write_strobe_n)
        else $error("write strobe width or data drive wrong");

    // address held through T2..T4
    a_addr_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == pio_pkg::ST_T2 || q.st == pio_pkg::ST_T3 || q.st == pio_pkg::ST_T4) |->
        $stable(ext_addr))
        else $error("off-chip address moved inside a cycle");

    // development mode offers no port at all
    a_dev_no_ports: assert property (@(posedge pclk) disable iff (!presetn)
        (q.mode_ok && q.mode == pio_pkg::MODE_DEVELOP) |->
        (port_a_oe_n == pio_pkg::ALL_INPUT && port_b_oe_n == pio_pkg::ALL_INPUT && port_c_out == pio_pkg::OUT_RESET))
        else $error("port driven in development mode");

    // external mode: port_b pins never driven, read goes off chip
    a_ext_portb_in: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && idle && mode_ext && !pwrite && ofs == pio_pkg::OFS_PORT_B) |->
        ##2 !io_read_strobe_n ##0 (port_b_oe_n == pio_pkg::ALL_INPUT))
        else $error("external port_b read did not strobe");

    // a port_c write in external mode runs the latch strobe
    a_ext_portc_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && idle && mode_ext && pwrite && ofs == pio_pkg::OFS_PORT_C) |->
        ##2 (!io_write_strobe_n && ext_data_out == $past(pwdata[PW-1:0], 2)))
        else $error("external port_c write did not strobe latch");

endmodule : pio_ports

/* File: tb/pio_pin_model.sv */
`timescale 1ns/1ps

// outside world of the port block: pin drivers, upper-byte latch and input buffer
module pio_pin_model (
    input wire logic pclk,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic [7:0] ext_data_out,
    input wire logic [7:0] ext_data_oe_n,
    input wire logic [7:0] buf_value,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe_n,
    input wire logic [7:0] pa_drive,
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_oe_n,
    input wire logic [7:0] pb_drive,
    output logic [7:0] ext_data_in,
    output logic [7:0] latch_q,
    output logic [7:0] port_a_in,
    output logic [7:0] port_b_in
);
    logic [7:0] last_q = 8'h00;

    // pin level: the device wins where it drives, else the outside driver
    assign port_a_in = (~port_a_oe_n & port_a_out) | (port_a_oe_n & pa_drive);
    assign port_b_in = (~port_b_oe_n & port_b_out) | (port_b_oe_n & pb_drive);

    // buffer drives only while the read strobe is low; a released bus toggles so stale data never looks valid
    assign ext_data_in = !io_read_strobe_n ? buf_value :
        ((~ext_data_oe_n & ext_data_out) | (ext_data_oe_n & ~last_q));

    always_ff @(posedge pclk) begin
        last_q <= ext_data_in;
    end

    // latch closes on the trailing edge of the write strobe
    initial latch_q = 8'h00;
    always @(posedge io_write_strobe_n) begin
        latch_q <= ext_data_in;
    end
endmodule : pio_pin_model

/* File: tb/pio_ports_bench.sv */
`timescale 1ns/1ps

module pio_ports_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [1:0] mode_strap = 2'h0;
    logic [7:0] pa_drive = 8'h3c;
    logic [7:0] pb_drive = 8'hc6;
    logic [7:0] buf_value = 8'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, io_read_strobe_n, io_write_strobe_n;
    logic [7:0] port_a_in, port_a_out, port_a_oe_n, port_b_in, port_b_out, port_b_oe_n, port_c_out;
    logic [7:0] ext_addr, ext_data_in, ext_data_out, ext_data_oe_n, latch_q, oe_sel, out_sel, drv_sel;
    logic [7:0] ofs_data [2];
    logic [7:0] ofs_dir [2];
    int fails = 0;
    int compares = 0;
    int rd_low = 0;
    int wr_low = 0;

    pio_ports #(.PW(8), .AW(8)) pio_ports_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_strap(mode_strap), .port_a_in(port_a_in), .port_a_out(port_a_out),
        .port_a_oe_n(port_a_oe_n), .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
        .port_c_out(port_c_out), .ext_addr(ext_addr), .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
        .ext_data_oe_n(ext_data_oe_n), .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n));

    pio_pin_model pio_pin_model_inst (.pclk(pclk), .io_read_strobe_n(io_read_strobe_n),
        .io_write_strobe_n(io_write_strobe_n), .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n),
        .buf_value(buf_value), .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n), .pa_drive(pa_drive),
        .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n), .pb_drive(pb_drive), .ext_data_in(ext_data_in),
        .latch_q(latch_q), .port_a_in(port_a_in), .port_b_in(port_b_in));

    // 125 mhz clock
    initial begin
        forever #4 pclk = ~pclk;
    end

    // strobe widths counted on the falling edge, away from the registered updates
    always @(negedge pclk) begin
        if (io_read_strobe_n === 1'b0) rd_low++;
        if (io_write_strobe_n === 1'b0) wr_low++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one apb transfer; pready, read data and error are taken at the rising edge, before its updates land
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // strap is only taken after reset release, so each mode needs its own reset
    task automatic do_reset(input logic [1:0] m);
        @(posedge pclk);
        presetn <= 1'b0;
        mode_strap <= m;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask : do_reset

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // hang guard, far beyond the roughly 120 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        final_report();
    end

    initial begin
        ofs_data[0] = pio_pkg::OFS_PORT_A;
        ofs_data[1] = pio_pkg::OFS_PORT_B;
        ofs_dir[0] = pio_pkg::OFS_PORT_A_DIR;
        ofs_dir[1] = pio_pkg::OFS_PORT_B_DIR;
        do_reset(pio_pkg::MODE_INTERNAL);
        // both bidirectional ports: mixed direction, read-back of outputs and synced inputs
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, ofs_dir[i], 32'h0);
            check("dir reset", rd, 32'h0);
            oe_sel = (i == 0) ? port_a_oe_n : port_b_oe_n;
            check("oe reset", oe_sel, 8'hff);
            apb(1'b1, ofs_dir[i], 32'h0000000f);
            apb(1'b1, ofs_data[i], 32'h000000a5);
            apb(1'b0, ofs_dir[i], 32'h0);
            check("dir value", rd, 32'h0000000f);
            oe_sel = (i == 0) ? port_a_oe_n : port_b_oe_n;
            out_sel = (i == 0) ? port_a_out : port_b_out;
            drv_sel = (i == 0) ? pa_drive : pb_drive;
            check("oe per bit", oe_sel, 8'hf0);
            check("port out", out_sel, 8'ha5);
            apb(1'b0, ofs_data[i], 32'h0);
            check("port read", rd, {24'h0, (8'ha5 & 8'h0f) | (drv_sel & 8'hf0)});
        end
        apb(1'b1, pio_pkg::OFS_PORT_C, 32'h0000005a);
        @(posedge pclk);
        check("port c out", port_c_out, 8'h5a);
        apb(1'b0, pio_pkg::OFS_MODE, 32'h0);
        check("mode", rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped err", err, 1'b1);
        // external rom mode: port c via latch, port b via buffer
        do_reset(pio_pkg::MODE_EXTERNAL);
        wr_low = 0;
        apb(1'b1, pio_pkg::OFS_PORT_C, 32'h00000096);
        check("latch", latch_q, 8'h96);
        check("write strobe width", wr_low, 3);
        check("write addr", ext_addr, pio_pkg::OFS_PORT_C);
        check("data still driven", ext_data_oe_n, 8'h00);
        check("port c pins idle", port_c_out, 8'h00);
        buf_value <= 8'hc3;
        rd_low = 0;
        apb(1'b0, pio_pkg::OFS_PORT_B, 32'h0);
        check("buffer read", rd, 32'h000000c3);
        check("read strobe width", rd_low, 3);
        check("read addr", ext_addr, pio_pkg::OFS_PORT_B);
        check("data released", ext_data_oe_n, 8'hff);
        apb(1'b1, pio_pkg::OFS_PORT_B_DIR, 32'h000000ff);
        apb(1'b1, pio_pkg::OFS_PORT_B, 32'h00000011);
        check("port b input only", port_b_oe_n, 8'hff);
        // development mode: no port at all
        do_reset(pio_pkg::MODE_DEVELOP);
        apb(1'b1, pio_pkg::OFS_PORT_A_DIR, 32'h000000ff);
        apb(1'b1, pio_pkg::OFS_PORT_A, 32'h00000033);
        check("dev port a oe", port_a_oe_n, 8'hff);
        apb(1'b0, pio_pkg::OFS_PORT_A, 32'h0);
        check("dev port a read", rd, 32'h0);
        apb(1'b1, pio_pkg::OFS_PORT_C, 32'h00000044);
        check("dev port c", port_c_out, 8'h00);
        final_report();
    end
endmodule : pio_ports_bench
